// [common/ecu_defines.vh]
// Constants for the two-channel edge counter unit.
// Overview of operation
// (R1) Two counters, each with 32-bit count.
// (R2) Count selected source edges only after arming.
// (R3) Setting selects rising or falling source edges.
// (R4) Setting selects upward or downward counting.
// (R5) Direction: up, down, or follow aux input.
// (R6) Count reads never disturb ongoing counting.
// (R7) Active pause trigger holds the count.
// (R8) Pause from gate, polarity selectable.
// (R9) Buffered mode captures count per sample edge.
// (R10) Cumulative capture leaves count unchanged.
// (R11) Sample clock on gate, edge selectable.
// (R12) Buffered counting starts at arming itself.
// (R13) Non-cumulative capture clears count after capture.
// (R14) External source pulses at least once between sample edges; the bench gives one to three between sample edges.
// (R15) Arming loads programmable initial value, default zero.
`ifndef ECU_DEFINES_VH
`define ECU_DEFINES_VH

// ------------------------------------------------------------
// Register map: window stride in bytes, word indices inside one counter window.
// ------------------------------------------------------------
`define ECU_CH_STRIDE      8'h20
`define ECU_OFF_CTRL       3'h0
`define ECU_OFF_INIT       3'h1
`define ECU_OFF_COUNT      3'h2
`define ECU_OFF_STATUS     3'h3

// ------------------------------------------------------------
// Control register fields.
// ------------------------------------------------------------
`define ECU_CTRL_W         9
`define ECU_CTRL_ARM       0
`define ECU_CTRL_SRC_FALL  1
`define ECU_CTRL_DIR_LO    2
`define ECU_CTRL_PAUSE_EN  4
`define ECU_CTRL_PAUSE_HI  5
`define ECU_CTRL_MODE_LO   6
`define ECU_CTRL_SMP_FALL  8
`define ECU_CTRL_RST       9'h000

// ------------------------------------------------------------
// Direction and mode encodings.
// ------------------------------------------------------------
`define ECU_DIR_UP         2'h0
`define ECU_DIR_DOWN       2'h1
`define ECU_DIR_AUX        2'h2
`define ECU_MODE_DEMAND    2'h0
`define ECU_MODE_CUMUL     2'h1
`define ECU_MODE_NONCUM    2'h2

// ------------------------------------------------------------
// Status register fields and reset values.
// ------------------------------------------------------------
`define ECU_STAT_ARMED     0
`define ECU_STAT_OVERRUN   1
`define ECU_STAT_GATE      2
`define ECU_INIT_RST       32'h0000_0000
`define ECU_NCH            2

`endif

// [core/ecu_core.v]
// Two-channel edge counter with AHB-Lite registers and DMA capture streams.
`timescale 1ns/1ps
`include "ecu_defines.vh"

module ecu_core (
   input  wire        mclk_i,      // System clock, 50 MHz.
   input  wire        sys_rst_i,   // Synchronous reset, active high.
   input  wire        hsel_i,      // AHB-Lite slave select.
   input  wire [31:0] haddr_i,     // AHB-Lite address.
   input  wire [1:0]  htrans_i,    // AHB-Lite transfer type.
   input  wire        hwrite_i,    // AHB-Lite write flag.
   input  wire [2:0]  hsize_i,     // AHB-Lite size, word only.
   input  wire [31:0] hwdata_i,    // AHB-Lite write data.
   input  wire        hready_i,    // AHB-Lite bus ready.
   output wire        hreadyout_o, // Slave ready, never stalls.
   output wire        hresp_o,     // Slave response, always OKAY.
   output reg  [31:0] hrdata_o,    // Registered read data.
   input  wire [1:0]  src_i,       // Source pins, one per counter.
   input  wire [1:0]  gate_i,      // Gate pins, one per counter.
   input  wire [1:0]  aux_i,       // Direction pins, one per counter.
   output wire [1:0]  dma_valid_o, // Capture word available.
   input  wire [1:0]  dma_ready_i, // DMA controller takes the word.
   output wire [63:0] dma_data_o   // Capture words, counter 1 high.
);

   // ---------------------------------------------------------
   // Helper functions.
   // ---------------------------------------------------------

   // Returns one when the channel counts upward.
   function up_dir;
      input [1:0] dir;
      input       aux;
      begin
         case (dir)
            `ECU_DIR_UP:   up_dir = 1'b1;
            `ECU_DIR_DOWN: up_dir = 1'b0;
            `ECU_DIR_AUX:  up_dir = aux;
            default:       up_dir = 1'b1;
         endcase
      end
   endfunction

   // Returns one on the selected edge of a sampled signal.
   function sel_edge;
      input cur;
      input prev;
      input fall;
      begin
         sel_edge = fall ? (prev & ~cur) : (cur & ~prev);
      end
   endfunction

   // ---------------------------------------------------------
   // Bus slave: address phase capture.
   // ---------------------------------------------------------
   reg         dp_wr;     // Data phase holds a write.
   reg         dp_ch;     // Counter addressed by the write.
   reg  [2:0]  dp_reg;    // Register addressed by the write.
   wire        ap_take;   // Address phase accepted this edge.
   wire        ap_ch;     // Counter addressed now.
   wire [2:0]  ap_reg;    // Register addressed now.
   wire        ap_ok;     // Address hits a register in a known window.

   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign ap_take     = hsel_i & htrans_i[1] & hready_i;
   assign ap_ch       = haddr_i[5];
   assign ap_reg      = haddr_i[4:2];
   assign ap_ok       = (haddr_i[31:6] == 26'h0) & (ap_reg <= `ECU_OFF_STATUS);

   // Latches the write target so data can be applied next cycle.
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         dp_wr  <= 1'b0;
         dp_ch  <= 1'b0;
         dp_reg <= 3'h0;
      end else begin
         dp_wr  <= ap_take & hwrite_i & ap_ok;
         dp_ch  <= ap_ch;
         dp_reg <= ap_reg;
      end
   end

   // ---------------------------------------------------------
   // Per-counter state gathered into flat vectors.
   // ---------------------------------------------------------
   wire [2*`ECU_CTRL_W-1:0] ctrl_v;   // Control words.
   wire [63:0]              init_v;   // Initial values.
   wire [63:0]              count_v;  // Live counts.
   wire [5:0]               stat_v;   // Status bits.

   // Registers the read word at the address phase so data comes from flops.
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (ap_take & ~hwrite_i) begin
         // Unmapped addresses read as zero.
         hrdata_o <= 32'h0000_0000;
         if (ap_ok) begin
            case (ap_reg)
               `ECU_OFF_CTRL: begin
                  hrdata_o <= {23'h0, ctrl_v[ap_ch*`ECU_CTRL_W +: `ECU_CTRL_W]};
               end
               `ECU_OFF_INIT: begin
                  hrdata_o <= init_v[ap_ch*32 +: 32];
               end
               `ECU_OFF_COUNT: begin
                  hrdata_o <= count_v[ap_ch*32 +: 32]; // see (R6)
               end
               `ECU_OFF_STATUS: begin
                  hrdata_o <= {29'h0, stat_v[ap_ch*3 +: 3]};
               end
               default: begin
                  hrdata_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------
   // Counter channels.
   // ---------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `ECU_NCH; g = g + 1) begin : ch
         reg  [`ECU_CTRL_W-1:0] ctrl;     // Control word.
         reg  [31:0]            init;     // Value loaded on arming.
         reg  [31:0]            count;    // The count itself.
         reg                    armed;    // Counting enabled.
         reg                    overrun;  // Capture lost, buffer full.
         reg  [1:0]             src_s;    // Source synchroniser.
         reg  [1:0]             gate_s;   // Gate synchroniser.
         reg  [1:0]             aux_s;    // Direction synchroniser.
         reg                    src_d;    // Previous synced source.
         reg                    gate_d;   // Previous synced gate.
         reg  [31:0]            buf0;     // Buffer head word.
         reg  [31:0]            buf1;     // Buffer second word.
         reg  [1:0]             fill;     // Words in the buffer.
         wire                   wr_me;    // Write aimed at this counter.
         wire                   arm_go;   // Arming edge from software.
         wire [1:0]             mode;     // Operating mode.
         wire                   buffered; // Either buffered mode.
         wire                   paused;   // Pause trigger active.
         wire                   src_hit;  // Selected source edge.
         wire                   smp_hit;  // Selected sample edge.
         wire                   step;     // Count this cycle.
         wire [31:0]            stepped;  // Count after one step.
         wire [31:0]            unit;     // Step from zero.
         wire                   push;     // Capture enters buffer.
         wire                   pop;      // DMA takes the head word.
         wire                   lost;     // Capture found buffer full.

         assign wr_me    = dp_wr & (dp_ch == g);
         assign arm_go   = wr_me & (dp_reg == `ECU_OFF_CTRL)
                           & hwdata_i[`ECU_CTRL_ARM] & ~armed;
         assign mode     = ctrl[`ECU_CTRL_MODE_LO +: 2];
         assign buffered = (mode == `ECU_MODE_CUMUL) | (mode == `ECU_MODE_NONCUM);
         // Pause applies outside the two buffered modes; in buffered modes gate is the sample clock.
         assign paused   = ~buffered & ctrl[`ECU_CTRL_PAUSE_EN]
                           & (gate_s[1] == ctrl[`ECU_CTRL_PAUSE_HI]); // see (R8)
         assign src_hit  = sel_edge(src_s[1], src_d, ctrl[`ECU_CTRL_SRC_FALL]); // see (R3)
         assign smp_hit  = armed & buffered
                           & sel_edge(gate_s[1], gate_d, ctrl[`ECU_CTRL_SMP_FALL]); // see (R11)
         assign step     = armed & src_hit & ~paused; // see (R2) see (R7)
         assign stepped  = up_dir(ctrl[`ECU_CTRL_DIR_LO +: 2], aux_s[1])
                           ? count + 32'h1 : count - 32'h1; // see (R4) see (R5)
         assign unit     = up_dir(ctrl[`ECU_CTRL_DIR_LO +: 2], aux_s[1])
                           ? 32'h1 : 32'hffff_ffff;
         assign pop      = (fill != 2'h0) & dma_ready_i[g];
         assign push     = smp_hit & ((fill != 2'h2) | pop); // see (R9)
         assign lost     = smp_hit & ~push;

         // Brings the pins into the clock domain through two flops each.
         always @(posedge mclk_i) begin
            if (sys_rst_i) begin
               src_s  <= 2'h0;
               gate_s <= 2'h0;
               aux_s  <= 2'h0;
               src_d  <= 1'b0;
               gate_d <= 1'b0;
            end else begin
               src_s  <= {src_s[0], src_i[g]};
               gate_s <= {gate_s[0], gate_i[g]};
               aux_s  <= {aux_s[0], aux_i[g]};
               src_d  <= src_s[1];
               gate_d <= gate_s[1];
            end
         end

         // Holds the software settings; arm bit is tracked by armed.
         always @(posedge mclk_i) begin
            if (sys_rst_i) begin
               ctrl  <= `ECU_CTRL_RST;
               init  <= `ECU_INIT_RST; // see (R15)
               armed <= 1'b0;
            end else if (wr_me) begin
               if (dp_reg == `ECU_OFF_CTRL) begin
                  ctrl  <= hwdata_i[`ECU_CTRL_W-1:0];
                  armed <= hwdata_i[`ECU_CTRL_ARM];
               end else if (dp_reg == `ECU_OFF_INIT) begin
                  init <= hwdata_i;
               end
            end
         end

         // Counts edges; arming loads the initial value first.
         always @(posedge mclk_i) begin
            if (sys_rst_i) begin
               count <= 32'h0000_0000;
            end else if (arm_go) begin
               count <= init; // see (R15) see (R12)
            end else if (smp_hit & (mode == `ECU_MODE_NONCUM)) begin
               // Clear after capture, keeping an edge of the same cycle.
               count <= step ? unit : 32'h0000_0000; // see (R13)
            end else if (step) begin
               // Cumulative capture falls here and leaves the count alone.
               count <= stepped; // see (R10)
            end
         end

         // Two-entry buffer; a stalled DMA loses a capture only when two words already wait.
         always @(posedge mclk_i) begin
            if (sys_rst_i) begin
               buf0 <= 32'h0000_0000;
               buf1 <= 32'h0000_0000;
               fill <= 2'h0;
            end else begin
               if (pop) begin
                  buf0 <= buf1;
               end
               if (push) begin
                  if ((fill == 2'h0) | ((fill == 2'h1) & pop)) begin
                     buf0 <= count; // see (R9)
                  end else begin
                     buf1 <= count;
                  end
               end
               fill <= fill + {1'b0, push} - {1'b0, pop};
            end
         end

         // Sticky overrun; a new loss wins over a same-cycle clear.
         always @(posedge mclk_i) begin
            if (sys_rst_i) begin
               overrun <= 1'b0;
            end else if (lost) begin
               overrun <= 1'b1;
            end else if (wr_me & (dp_reg == `ECU_OFF_STATUS)
                         & hwdata_i[`ECU_STAT_OVERRUN]) begin
               overrun <= 1'b0;
            end
         end

         assign ctrl_v[g*`ECU_CTRL_W +: `ECU_CTRL_W] = {ctrl[`ECU_CTRL_W-1:1], armed};
         assign init_v[g*32 +: 32]   = init;
         assign count_v[g*32 +: 32]  = count; // see (R1)
         assign stat_v[g*3 +: 3]     = {gate_s[1], overrun, armed};
         assign dma_valid_o[g]       = (fill != 2'h0);
         assign dma_data_o[g*32 +: 32] = buf0;
      end
   endgenerate

endmodule

// [tb/ecu_core_sva.sv]
// Concurrent checks on the ports of the edge counter unit.
`timescale 1ns/1ps
module ecu_core_sva (
   input wire        mclk_i,
   input wire        sys_rst_i,
   input wire        hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0]  htrans_i,
   input wire        hwrite_i,
   input wire        hready_i,
   input wire        hreadyout_o,
   input wire        hresp_o,
   input wire [31:0] hrdata_o,
   input wire [1:0]  dma_valid_o,
   input wire [1:0]  dma_ready_i,
   input wire [63:0] dma_data_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // A read address phase that the slave takes.
   wire rd_take = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
   chk_never_waits: assert property (hreadyout_o && !hresp_o)
      else $error("slave stalled or did not answer OKAY");
   chk_rst_clears: assert property (
      disable iff (1'b0) sys_rst_i |=> (dma_valid_o == 2'h0 && hrdata_o == 32'h0))
      else $error("reset left a stream word or read data");
   chk_rdata_holds: assert property (!rd_take |=> $stable(hrdata_o))
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (
      rd_take && haddr_i[31:6] != 26'h0 |=> hrdata_o == 32'h0)
      else $error("unmapped read returned nonzero");
   chk_hold_word0: assert property (
      dma_valid_o[0] && !dma_ready_i[0] |=> dma_valid_o[0] && $stable(dma_data_o[31:0]))
      else $error("stalled capture word 0 was lost or changed");
   chk_hold_word1: assert property (
      dma_valid_o[1] && !dma_ready_i[1] |=> dma_valid_o[1] && $stable(dma_data_o[63:32]))
      else $error("stalled capture word 1 was lost or changed");
   chk_idle_quiet: assert property ($fell(sys_rst_i) |-> (dma_valid_o == 2'h0) [*2])
      else $error("stream word appeared straight after reset");
   // An unused register slot inside a counter window must read as zero.
   chk_hole_zero: assert property (
      rd_take && haddr_i[4:2] > 3'h3 |=> hrdata_o == 32'h0)
      else $error("read of an unused register slot returned nonzero");
   cover property (dma_valid_o[0] && !dma_ready_i[0]);
   cover property (dma_valid_o[1] && dma_ready_i[1]);
   cover property (rd_take);
endmodule
bind ecu_core ecu_core_sva chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
   .dma_valid_o(dma_valid_o), .dma_ready_i(dma_ready_i), .dma_data_o(dma_data_o));

// [tb/ecu_core_tb.sv]
// Self-checking bench for the edge counter unit.
`timescale 1ns/1ps
module ecu_core_tb;
   logic        mclk_i = 1'b0;    // System clock, 20 ns.
   logic        sys_rst_i = 1'b1; // Reset, held 16 cycles.
   logic        hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0;
   logic [31:0] rd;               // Last word read.
   wire         hreadyout_o;
   wire         hresp_o;
   wire  [31:0] hrdata_o;
   wire  [1:0]  src, gate, aux, rdy, vld;
   wire  [63:0] dat;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   always #10 mclk_i = ~mclk_i;
   ecu_core uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .hrdata_o(hrdata_o), .src_i(src), .gate_i(gate), .aux_i(aux), .dma_valid_o(vld),
      .dma_ready_i(rdy), .dma_data_o(dat));
   ecu_far_model far (.mclk_i(mclk_i), .dma_valid_i(vld), .dma_data_i(dat), .src_o(src),
      .gate_o(gate), .aux_o(aux), .dma_ready_o(rdy));
   // One AHB-Lite single word: address phase, then data phase.
   task xfer(input logic wr, input [31:0] a, input [31:0] d);
      @(posedge mclk_i);
      hsel_i <= 1'b1;
      haddr_i <= a;
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task rdc(input [31:0] a, input [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task finish_test;
      $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Watchdog: the sequence needs about five hundred cycles.
   initial begin
      repeat (20000) @(posedge mclk_i);
      n_mismatch++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      // Reset values, an unmapped word, no counting before arming.
      rdc(32'h04, 32'h0);
      rdc(32'h40, 32'h0);
      rdc(32'h10, 32'h0);
      far.pulse(0, 2);
      rdc(32'h08, 32'h0);
      // Arm counter 0 up from an initial value; reads do not disturb it.
      xfer(1'b1, 32'h04, 32'h5);
      xfer(1'b1, 32'h00, 32'h1);
      far.pulse(0, 3);
      rdc(32'h08, 32'h8);
      rdc(32'h08, 32'h8);
      far.pulse(0, 1);
      rdc(32'h08, 32'h9);
      // Direction follows the aux pin; no reload while armed.
      xfer(1'b1, 32'h00, 32'h9);
      far.pulse(0, 1);
      rdc(32'h08, 32'h8);
      far.put(2, 0, 1'b1);
      far.pulse(0, 2);
      rdc(32'h08, 32'ha);
      // Pause while gate is high.
      xfer(1'b1, 32'h00, 32'h31);
      far.put(1, 0, 1'b1);
      far.pulse(0, 2);
      rdc(32'h08, 32'ha);
      far.put(1, 0, 1'b0);
      far.pulse(0, 1);
      rdc(32'h08, 32'hb);
      // Pause while gate is low: the gate pin sits low here, so no edge counts.
      xfer(1'b1, 32'h00, 32'h11);
      far.pulse(0, 1);
      rdc(32'h08, 32'hb);
      // Counter 1 counts falling edges downward over the full width.
      xfer(1'b1, 32'h24, 32'h8000_000a);
      xfer(1'b1, 32'h20, 32'h7);
      far.put(0, 1, 1'b1);
      rdc(32'h28, 32'h8000_000a);
      far.put(0, 1, 1'b0);
      rdc(32'h28, 32'h8000_0009);
      // Cumulative capture on counter 0, receiver stalled until overrun.
      xfer(1'b1, 32'h00, 32'h0);
      xfer(1'b1, 32'h04, 32'h0);
      xfer(1'b1, 32'h00, 32'h41);
      far.put(3, 0, 1'b1);
      far.pulse(0, 2);
      for (int i = 0; i < 3; i++) begin
         far.put(1, 0, 1'b1);
         far.put(1, 0, 1'b0);
         far.pulse(0, 1);
      end
      far.put(1, 0, 1'b1);
      rdc(32'h0c, 32'h7);
      rdc(32'h08, 32'h5);
      far.put(3, 0, 1'b0);
      chk(far.got0.size(), 32'h2);
      chk(far.got0[0], 32'h2);
      chk(far.got0[1], 32'h3);
      chk({31'h0, vld[0]}, 32'h0);
      // Clearing the sticky overrun leaves gate level and armed standing.
      xfer(1'b1, 32'h0c, 32'h2);
      rdc(32'h0c, 32'h5);
      // Non-cumulative capture on counter 1 at falling gate edges.
      xfer(1'b1, 32'h20, 32'h0);
      xfer(1'b1, 32'h24, 32'h0);
      xfer(1'b1, 32'h20, 32'h181);
      far.put(1, 1, 1'b1);
      far.pulse(1, 2);
      far.put(1, 1, 1'b0);
      far.pulse(1, 3);
      far.put(1, 1, 1'b1);
      far.put(1, 1, 1'b0);
      rdc(32'h28, 32'h0);
      chk(far.got1.size(), 32'h2);
      chk(far.got1[0], 32'h2);
      chk(far.got1[1], 32'h3);
      finish_test;
   end
endmodule

// [tb/ecu_far_model.sv]
// Pins and DMA taker on the far side of the edge counter unit.
`timescale 1ns/1ps
module ecu_far_model (
   input  wire         mclk_i,
   input  wire  [1:0]  dma_valid_i,
   input  wire  [63:0] dma_data_i,
   output logic [1:0]  src_o,
   output logic [1:0]  gate_o,
   output logic [1:0]  aux_o,
   output wire  [1:0]  dma_ready_o
);
   logic [1:0]  stall = 2'h0;  // Stalls the DMA taker per counter.
   logic [31:0] got0[$];       // Words taken from counter 0.
   logic [31:0] got1[$];       // Words taken from counter 1.
   assign dma_ready_o = ~stall;
   initial begin
      src_o = 2'h0;
      gate_o = 2'h0;
      aux_o = 2'h0;
   end
   // Take a word at each edge where valid and ready meet.
   always @(posedge mclk_i) begin
      if (dma_valid_i[0] && dma_ready_o[0]) got0.push_back(dma_data_i[31:0]);
      if (dma_valid_i[1] && dma_ready_o[1]) got1.push_back(dma_data_i[63:32]);
   end
   // Sets one pin and holds it long enough for the synchroniser.
   task put(input int sel, input int ch, input logic v);
      @(posedge mclk_i);
      case (sel)
         0: src_o[ch] <= v;
         1: gate_o[ch] <= v;
         2: aux_o[ch] <= v;
         default: stall[ch] <= v;
      endcase
      repeat (5) @(posedge mclk_i);
   endtask
   // Whole source pulses; callers give one to three between sample edges.
   task pulse(input int ch, input int n);
      repeat (n) begin
         put(0, ch, 1'b1);
         put(0, ch, 1'b0);
      end
   endtask
endmodule
